//--- core/lst_timing_gen.sv
// Display sync timing generator driving a parallel RGB panel
// Function
// [R1] Line back porch counts pixel clocks from line sync start to first pixel
// [R2] Line front porch counts pixel clocks from last pixel to next line sync
// [R3] Vertical back porch counts lines from frame sync start to first line
// [R4] Vertical front porch counts lines from last valid line to frame sync
// [R5] Frame sync lasts the programmed number of lines
// [R6] Line sync lasts the programmed number of pixel clocks
// [R7] Each line carries exactly the programmed active width of pixels
// [R8] Each frame carries exactly the programmed active height of lines
// [R9] Line period equals active width plus both horizontal porches
// [R10] Frame period equals active height plus both vertical porches
// [R11] Frame sync polarity 0 gives active low, 1 active high
// [R12] Line sync polarity 0 gives active low, 1 active high
// [R13] Unused sync pins may be given over to other functions
// [R14] Data enable only with valid pixels; panel latches one per clock
// [R15] High clock polarity: data changes on fall, panel samples on rise
// [R16] Enable low in porches and syncs; runs continuously, restarts per frame
`timescale 1ns/1ps
module lst_timing_gen #(
   parameter int W = lst_pkg::CNT_W,
   parameter int CAP_DEPTH = 4
) (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic enable_in,
   input wire logic [W-1:0] h_back_porch_in,
   input wire logic [W-1:0] h_front_porch_in,
   input wire logic [W-1:0] h_sync_width_in,
   input wire logic [W-1:0] h_active_in,
   input wire logic [W-1:0] v_back_porch_in,
   input wire logic [W-1:0] v_front_porch_in,
   input wire logic [W-1:0] v_sync_width_in,
   input wire logic [W-1:0] v_active_in,
   input wire logic frame_sync_pol_in,
   input wire logic line_sync_pol_in,
   input wire logic pixel_clock_out_pol_in,
   input wire logic frame_sync_alt_in,
   input wire logic line_sync_alt_in,
   input wire logic frame_alt_data_in,
   input wire logic dma_debug_event_alt_in,
   input wire logic [1:0] cap_sel_in,
   output logic frame_sync_pin_out,
   output logic line_sync_pin_out,
   output logic pixel_valid_out,
   output logic pixel_clock_out,
   output logic pixel_strobe_out,
   output logic running_out,
   output logic [2:0] cap_data_out
);
   localparam int AW = $clog2(CAP_DEPTH);

   // Compare a count against a sum of two settings without overflow
   function automatic logic [W:0] add2(input logic [W-1:0] a,
                                       input logic [W-1:0] b);
      add2 = {1'b0, a} + {1'b0, b};
   endfunction

   lst_pkg::lst_state_t state_reg, state_next;
   logic [1:0] div_reg, div_next;
   logic [W:0] h_cnt_reg, h_cnt_next;
   logic [W:0] v_cnt_reg, v_cnt_next;
   logic fs_reg, fs_next;
   logic ls_reg, ls_next;
   logic de_reg, de_next;
   logic pclk_reg, pclk_next;
   logic stb_reg, stb_next;
   logic run_reg, run_next;
   logic [AW-1:0] cap_ptr_reg, cap_ptr_next;
   logic [W:0] h_total, v_total;
   logic [W:0] h_ab, v_ab;
   logic h_end, v_end, phase;
   logic h_act, v_act, h_sync, v_sync;

   // Pixel period is two core clocks: one phase drives, the other samples
   assign phase = (div_reg == lst_pkg::PIX_DIV_HALF);
   // Active plus back porch sums wrap at the field width; settings are kept small enough
   assign h_ab = add2(h_active_in, h_back_porch_in);
   assign h_total = add2(h_ab[W-1:0], h_front_porch_in); // R9
   assign v_ab = add2(v_active_in, v_back_porch_in);
   assign v_total = add2(v_ab[W-1:0], v_front_porch_in); // R10
   assign h_end = (h_cnt_reg + {lst_pkg::DEF_ZERO, 1'b1} >= h_total); // R9
   assign v_end = (v_cnt_reg + {lst_pkg::DEF_ZERO, 1'b1} >= v_total); // R10
   // Sync width lies inside the back porch, counted from sync start
   assign h_sync = (h_cnt_reg < {1'b0, h_sync_width_in}); // R6
   assign v_sync = (v_cnt_reg < {1'b0, v_sync_width_in}); // R5
   assign h_act = (h_cnt_reg >= {1'b0, h_back_porch_in}) &&
                  (h_cnt_reg < add2(h_back_porch_in, h_active_in)); // R1 R2 R7
   assign v_act = (v_cnt_reg >= {1'b0, v_back_porch_in}) &&
                  (v_cnt_reg < add2(v_back_porch_in, v_active_in)); // R3 R4 R8

   always_comb begin
      state_next = state_reg;
      div_next = div_reg;
      h_cnt_next = h_cnt_reg;
      v_cnt_next = v_cnt_reg;
      run_next = run_reg;
      case (state_reg)
         lst_pkg::LST_IDLE: begin
            div_next = '0;
            h_cnt_next = '0;
            v_cnt_next = '0;
            run_next = 1'b0;
            if (enable_in) begin
               state_next = lst_pkg::LST_RUN;
            end
         end
         lst_pkg::LST_RUN: begin
            run_next = 1'b1;
            div_next = phase ? 2'h0 : div_reg + 2'h1;
            if (phase) begin
               if (h_end) begin
                  h_cnt_next = '0;
                  v_cnt_next = v_end ? '0 : v_cnt_reg + 1'b1; // R16
               end else begin
                  h_cnt_next = h_cnt_reg + 1'b1;
               end
            end
            if (!enable_in) begin
               state_next = lst_pkg::LST_IDLE;
            end
         end
         default: begin
            state_next = lst_pkg::LST_IDLE;
         end
      endcase
   end

   always_comb begin
      fs_next = fs_reg;
      ls_next = ls_reg;
      de_next = de_reg;
      pclk_next = pixel_clock_out_pol_in;
      stb_next = 1'b0;
      if (state_reg != lst_pkg::LST_RUN) begin
         fs_next = ~frame_sync_pol_in;
         ls_next = ~line_sync_pol_in;
         de_next = 1'b0;
      end else if (!phase) begin
         // Drive edge: data, sync and enable change here
         pclk_next = ~pixel_clock_out_pol_in; // R15
         fs_next = v_sync ? frame_sync_pol_in : ~frame_sync_pol_in; // R11
         ls_next = h_sync ? line_sync_pol_in : ~line_sync_pol_in; // R12
         de_next = h_act && v_act; // R14 R16
      end else begin
         // Sample edge for the panel
         pclk_next = pixel_clock_out_pol_in; // R15
         stb_next = de_reg; // R14
      end
      // Pins handed over to other use when no sync is wanted
      if (frame_sync_alt_in) begin
         fs_next = frame_alt_data_in; // R13
      end
      if (line_sync_alt_in) begin
         ls_next = dma_debug_event_alt_in; // R13
      end
   end

   always_comb begin
      cap_ptr_next = cap_ptr_reg;
      if (phase && h_end && v_end) begin
         cap_ptr_next = cap_ptr_reg + 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_reg <= lst_pkg::LST_IDLE;
         div_reg <= 2'h0;
         h_cnt_reg <= '0;
         v_cnt_reg <= '0;
         fs_reg <= 1'b1;
         ls_reg <= 1'b1;
         de_reg <= 1'b0;
         pclk_reg <= 1'b0;
         stb_reg <= 1'b0;
         run_reg <= 1'b0;
         cap_ptr_reg <= '0;
      end else begin
         state_reg <= state_next;
         div_reg <= div_next;
         h_cnt_reg <= h_cnt_next;
         v_cnt_reg <= v_cnt_next;
         fs_reg <= fs_next;
         ls_reg <= ls_next;
         de_reg <= de_next;
         pclk_reg <= pclk_next;
         stb_reg <= stb_next;
         run_reg <= run_next;
         cap_ptr_reg <= cap_ptr_next;
      end
   end

   assign frame_sync_pin_out = fs_reg;
   assign line_sync_pin_out = ls_reg;
   assign pixel_valid_out = de_reg;
   assign pixel_clock_out = pclk_reg;
   assign pixel_strobe_out = stb_reg;
   assign running_out = run_reg;

   // Snapshot of the pin levels at each frame end, for software inspection
   lst_cap_mem #(
      .DEPTH(CAP_DEPTH),
      .WIDTH(3)
   ) u_cap (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .wr_in(phase && h_end && v_end),
      .waddr_in(cap_ptr_reg),
      .wdata_in({de_reg, ls_reg, fs_reg}),
      .raddr_in(cap_sel_in[AW-1:0]),
      .rdata_out(cap_data_out)
   );

   logic [W:0] de_run_reg;
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         de_run_reg <= '0;
      end else if (stb_reg) begin
         de_run_reg <= de_run_reg + 1'b1;
      end else if (!de_reg) begin
         de_run_reg <= '0;
      end
   end

   property p_de_off_in_hsync;
      @(posedge core_clk_in) disable iff (!rstn_in)
      (state_reg == lst_pkg::LST_RUN && !phase && h_sync
       && h_sync_width_in <= h_back_porch_in) |=> !de_reg;
   endproperty
   a_de_off_in_hsync: assert property (p_de_off_in_hsync) // R16
      else $error("enable active during line sync");

   property p_de_off_in_vsync;
      @(posedge core_clk_in) disable iff (!rstn_in)
      (state_reg == lst_pkg::LST_RUN && !phase && v_sync
       && v_sync_width_in <= v_back_porch_in) |=> !de_reg;
   endproperty
   a_de_off_in_vsync: assert property (p_de_off_in_vsync) // R16
      else $error("enable active during frame sync");

   property p_strobe_only_valid;
      @(posedge core_clk_in) disable iff (!rstn_in)
      stb_reg |-> de_reg;
   endproperty
   a_strobe_only_valid: assert property (p_strobe_only_valid) // R14
      else $error("strobe without valid pixel");

   property p_idle_quiet;
      @(posedge core_clk_in) disable iff (!rstn_in)
      (state_reg == lst_pkg::LST_IDLE) |=> (!de_reg && !stb_reg);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) // R16
      else $error("enable or strobe active while stopped");

   property p_line_pixels;
      @(posedge core_clk_in) disable iff (!rstn_in)
      // Last pixel's strobe is still pending in the run counter here
      (de_reg && !de_next && state_reg == lst_pkg::LST_RUN)
      |-> (de_run_reg + {{W{1'b0}}, stb_reg} == {1'b0, h_active_in});
   endproperty
   a_line_pixels: assert property (p_line_pixels) // R7
      else $error("wrong number of valid pixels in line");

   property p_strobe_follows;
      @(posedge core_clk_in) disable iff (!rstn_in)
      (de_reg && phase && state_reg == lst_pkg::LST_RUN) |=> stb_reg;
   endproperty
   a_strobe_follows: assert property (p_strobe_follows) // R14
      else $error("no strobe for valid pixel");

   sequence s_pclk_drive;
      pclk_reg == ~pixel_clock_out_pol_in;
   endsequence

   sequence s_pclk_sample;
      pclk_reg == pixel_clock_out_pol_in;
   endsequence

   property p_clk_pol;
      @(posedge core_clk_in) disable iff (!rstn_in)
      (state_reg == lst_pkg::LST_RUN && !phase && !$changed(pixel_clock_out_pol_in))
      |=> s_pclk_drive ##1 s_pclk_sample;
   endproperty
   a_clk_pol: assert property (p_clk_pol) // R15
      else $error("pixel clock edge order wrong");

   property p_vsync_level;
      @(posedge core_clk_in) disable iff (!rstn_in)
      (state_reg == lst_pkg::LST_RUN && !phase && v_sync
       && !frame_sync_alt_in) |=> (fs_reg == $past(frame_sync_pol_in));
   endproperty
   a_vsync_level: assert property (p_vsync_level) // R11
      else $error("frame sync level wrong");

   property p_hsync_level;
      @(posedge core_clk_in) disable iff (!rstn_in)
      (state_reg == lst_pkg::LST_RUN && !phase && !h_sync
       && !line_sync_alt_in) |=> (ls_reg == ~$past(line_sync_pol_in));
   endproperty
   a_hsync_level: assert property (p_hsync_level) // R12
      else $error("line sync idle level wrong");

   property p_h_wrap;
      @(posedge core_clk_in) disable iff (!rstn_in)
      (state_reg == lst_pkg::LST_RUN && phase && enable_in
       && h_cnt_reg + 1'b1 == h_total) |=> (h_cnt_reg == '0);
   endproperty
   a_h_wrap: assert property (p_h_wrap) // R9
      else $error("line period wrong");

   property p_v_wrap;
      @(posedge core_clk_in) disable iff (!rstn_in)
      (state_reg == lst_pkg::LST_RUN && phase && enable_in && h_end
       && v_cnt_reg + 1'b1 == v_total) |=> (v_cnt_reg == '0);
   endproperty
   a_v_wrap: assert property (p_v_wrap) // R10
      else $error("frame period wrong");
endmodule // lst_timing_gen

//--- core/lst_pkg.sv
// Package with timing field widths, reset values and state codes
package lst_pkg;
   localparam int CNT_W = 12;
   localparam logic [11:0] DEF_ZERO = 12'h000;
   localparam logic [11:0] CNT_ONE = 12'h001;
   localparam logic [1:0] PIX_DIV_HALF = 2'h1;
   localparam logic [3:0] FRAME_SYNC_POS = 4'h0;
   localparam logic [3:0] LINE_SYNC_POS = 4'h1;
   localparam logic [3:0] PIXEL_VALID_POS = 4'h2;
   localparam logic [3:0] CAPTURE_BITS = 4'h3;
   typedef enum logic [1:0] {
      LST_IDLE = 2'b00,
      LST_RUN = 2'b01
   } lst_state_t;
endpackage

//--- core/lst_cap_mem.sv
// Small memory that records the last few sync and valid snapshots
`timescale 1ns/1ps
module lst_cap_mem #(
   parameter int DEPTH = 4,
   parameter int WIDTH = 3
) (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic wr_in,
   input wire logic [$clog2(DEPTH)-1:0] waddr_in,
   input wire logic [WIDTH-1:0] wdata_in,
   input wire logic [$clog2(DEPTH)-1:0] raddr_in,
   output logic [WIDTH-1:0] rdata_out
);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   always_ff @(posedge core_clk_in) begin
      if (wr_in) begin
         mem_reg[waddr_in] <= wdata_in;
      end
   end
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= mem_reg[raddr_in];
      end
   end
endmodule // lst_cap_mem

//--- sim/lst_panel_model.sv
// Panel model that latches pixels and measures the sync timing it sees
`timescale 1ns/1ps
module lst_panel_model (
   input wire logic pclk_in,
   input wire logic pclk_pol_in,
   input wire logic line_pol_in,
   input wire logic frame_pol_in,
   input wire logic line_sync_in,
   input wire logic frame_sync_in,
   input wire logic de_in
);
   logic samp;
   logic ls;
   logic fs;
   logic ls_q = 1'b0;
   logic fs_q = 1'b0;
   logic had_de = 1'b0;
   logic had_fs = 1'b0;
   int h_cnt = 0, px = 0, first = 0, hsw = 0, v_cnt = 0, vl = 0, vfirst = 0;
   int vsw = 0, line_len = 0, line_px = 0, line_first = 0, line_hsw = 0;
   int frame_len = 0, frame_vl = 0, frame_first = 0, frame_vsw = 0;
   int de_in_sync = 0;
   int tot_px = 0;
   assign samp = pclk_pol_in ? pclk_in : ~pclk_in;
   assign ls = line_sync_in == line_pol_in;
   assign fs = frame_sync_in == frame_pol_in;
   // One pixel latched per sample edge while data enable is up
   always @(posedge samp) begin
      if (ls && !ls_q) begin
         if (had_de) begin
            line_len = h_cnt;
            line_px = px;
            line_first = first;
            line_hsw = hsw;
            if (vl == 0)
               vfirst = v_cnt;
            vl++;
         end
         if (had_fs)
            vsw++;
         v_cnt++;
         if (fs && !fs_q) begin
            frame_len = v_cnt;
            frame_vl = vl;
            frame_first = vfirst;
            frame_vsw = vsw;
            v_cnt = 0;
            vl = 0;
            vsw = 0;
         end
         h_cnt = 0;
         px = 0;
         hsw = 0;
         had_de = 1'b0;
         had_fs = 1'b0;
      end
      if (de_in && px == 0)
         first = h_cnt;
      if (de_in) begin
         px++;
         tot_px++;
      end
      if (ls)
         hsw++;
      if (de_in && (ls || fs))
         de_in_sync++;
      had_de = had_de | de_in;
      had_fs = had_fs | fs;
      h_cnt++;
      ls_q = ls;
      fs_q = fs;
   end
endmodule // lst_panel_model

//--- sim/testbench.sv
// Self-checking bench for the display sync timing generator
`timescale 1ns/1ps
module testbench;
   logic core_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic enable_in = 1'b0;
   logic [11:0] h_back_porch = 12'h000, h_front_porch = 12'h000;
   logic [11:0] h_sync_w = 12'h000, h_act = 12'h000, v_sync_w = 12'h000;
   logic [11:0] v_back_porch = 12'h000, v_front_porch = 12'h000;
   logic [11:0] v_act = 12'h000;
   logic fs_pol = 1'b0, ls_pol = 1'b0, ck_pol = 1'b1;
   logic fs_alt = 1'b0, ls_alt = 1'b0, fs_dat = 1'b0, ls_dat = 1'b0;
   logic fs_pin, ls_pin, de, pclk, running_out;
   logic stb;
   logic [2:0] cap;
   int n_stb = 0;
   int n_fail = 0;
   int samples_checked = 0;
   always #10 core_clk_in = ~core_clk_in;
   // Strobe pulses are one cycle wide and never back to back
   always @(posedge stb) n_stb++;
   lst_timing_gen u_lst_timing_gen (.core_clk_in(core_clk_in),
      .rstn_in(rstn_in), .enable_in(enable_in),
      .h_back_porch_in(h_back_porch), .h_front_porch_in(h_front_porch),
      .h_sync_width_in(h_sync_w), .h_active_in(h_act),
      .v_back_porch_in(v_back_porch), .v_front_porch_in(v_front_porch),
      .v_sync_width_in(v_sync_w), .v_active_in(v_act),
      .frame_sync_pol_in(fs_pol), .line_sync_pol_in(ls_pol),
      .pixel_clock_out_pol_in(ck_pol), .frame_sync_alt_in(fs_alt),
      .line_sync_alt_in(ls_alt), .frame_alt_data_in(fs_dat),
      .dma_debug_event_alt_in(ls_dat), .cap_sel_in(2'h1),
      .frame_sync_pin_out(fs_pin), .line_sync_pin_out(ls_pin),
      .pixel_valid_out(de), .pixel_clock_out(pclk), .pixel_strobe_out(stb),
      .running_out(running_out), .cap_data_out(cap));
   lst_panel_model u_lst_panel_model (.pclk_in(pclk), .pclk_pol_in(ck_pol),
      .line_pol_in(ls_pol), .frame_pol_in(fs_pol), .line_sync_in(ls_pin),
      .frame_sync_in(fs_pin), .de_in(de));
   task automatic chk(input string n, input logic [11:0] e,
                      input logic [11:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %0d seen %0d", n, e, g);
      end
   endtask
   task automatic wrap_up();
      if (n_fail == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic run_cfg(input logic [11:0] hs, hb, ha, hf, vs, vb, va, vf,
                          input logic fp, lp, cp);
      int n;
      int s0;
      int p0;
      @(posedge core_clk_in);
      #2;
      h_sync_w = hs;
      h_back_porch = hb;
      h_act = ha;
      h_front_porch = hf;
      v_sync_w = vs;
      v_back_porch = vb;
      v_act = va;
      v_front_porch = vf;
      fs_pol = fp;
      ls_pol = lp;
      ck_pol = cp;
      s0 = n_stb;
      p0 = u_lst_panel_model.tot_px;
      enable_in = 1'b1;
      // Three frames let the panel see two whole frames after start-up
      n = 6 * (ha + hb + hf) * (va + vb + vf) + 50;
      repeat (n) @(posedge core_clk_in);
      #2;
      chk("line_period", ha + hb + hf, u_lst_panel_model.line_len);
      chk("h_back", hb, u_lst_panel_model.line_first);
      chk("active_px", ha, u_lst_panel_model.line_px);
      chk("h_front", hf, u_lst_panel_model.line_len - ha - hb);
      chk("line_sync_w", hs, u_lst_panel_model.line_hsw);
      chk("frame_period", va + vb + vf, u_lst_panel_model.frame_len);
      chk("v_back", vb, u_lst_panel_model.frame_first);
      chk("active_ln", va, u_lst_panel_model.frame_vl);
      chk("v_front", vf, u_lst_panel_model.frame_len - va - vb);
      chk("frame_sync_w", vs, u_lst_panel_model.frame_vsw);
      chk("de_in_sync", 12'h000, u_lst_panel_model.de_in_sync);
      chk("running", 12'h001, {11'h000, running_out});
      chk("strobes", u_lst_panel_model.tot_px - p0, n_stb - s0);
      enable_in = 1'b0;
      repeat (8) @(posedge core_clk_in);
      #2;
      chk("stopped", 12'h000, {11'h000, running_out});
      chk("de_idle", 12'h000, {11'h000, de});
   endtask
   initial begin
      repeat (4) @(posedge core_clk_in);
      #2;
      rstn_in = 1'b1;
      run_cfg(12'h002, 12'h005, 12'h008, 12'h003, 12'h002, 12'h003,
              12'h004, 12'h002, 1'b0, 1'b0, 1'b1);
      // Frame end snapshot: enable off, both syncs at their idle level
      chk("cap_snap", 12'h003, {9'h000, cap});
      run_cfg(12'h003, 12'h003, 12'h005, 12'h000, 12'h001, 12'h001,
              12'h003, 12'h000, 1'b1, 1'b1, 1'b0);
      run_cfg(12'h001, 12'h001, 12'h001, 12'h001, 12'h001, 12'h002,
              12'h001, 12'h001, 1'b0, 1'b1, 1'b1);
      run_cfg(12'h004, 12'h006, 12'h00A, 12'h002, 12'h003, 12'h004,
              12'h005, 12'h003, 1'b1, 1'b0, 1'b0);
      // Pins handed over to alternate data follow that data
      fs_alt = 1'b1;
      ls_alt = 1'b1;
      for (int i = 0; i < 2; i++) begin
         fs_dat = i[0];
         ls_dat = ~i[0];
         repeat (3) @(posedge core_clk_in);
         #2;
         chk("frame_alt", {11'h000, i[0]}, {11'h000, fs_pin});
         chk("line_alt", {11'h000, ~i[0]}, {11'h000, ls_pin});
      end
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge core_clk_in);
      n_fail++;
      wrap_up();
   end
endmodule // testbench
